// ==== shared/tdcrs_pkg.sv ====
// Purpose: Shared constants and types of the result, status and NVM store block.
// Assumes: 100 MHz clock, one 32-bit word per result register.
// Notes: Register addresses are the read-opcode low nibble.
package tdcrs_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [3:0] ADDR_RES0 = 4'h0;
  localparam logic [3:0] ADDR_RES3 = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CFG1_HI = 4'h5;
  localparam logic [3:0] ADDR_FWR = 4'h8;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_READ_BASE = 8'hb0;
  localparam logic [7:0] CMD_NVM_STORE = 8'hc0;
  localparam logic [7:0] CMD_NVM_RECALL = 8'hf0;
  localparam logic [7:0] CMD_NVM_COMPARE = 8'hc6;
  localparam logic [7:0] CMD_INIT = 8'h70;

  // ****************************************
  // Result formats
  // ****************************************
  localparam logic [31:0] RES_OVERFLOW = 32'h0fffffff;
  localparam logic [15:0] RES_FRAC_ZERO = 16'h0000;
  localparam int RES_FRAC_BITS = 16;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int ST_PTR_LSB = 0;
  localparam int ST_HIT1_LSB = 3;
  localparam int ST_HIT2_LSB = 6;
  localparam int ST_TDC_OVF = 9;
  localparam int ST_PRE_OVF = 10;
  localparam int ST_OPEN = 11;
  localparam int ST_SHORT = 12;
  localparam int ST_NVM_SEC = 13;
  localparam int ST_NVM_DED = 14;
  localparam int ST_NVM_EQ = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0] FWR_RESET = 8'h00;

  // ****************************************
  // NVM geometry and timing
  // ****************************************
  localparam int NVM_WORDS = 7;
  localparam int NVM_CODE_W = 39;
  localparam int NVM_OP_MS = 130;
  localparam int CLK_HZ = 100_000_000;
  localparam int NVM_OP_CYCLES = NVM_OP_MS * (CLK_HZ / 1000);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {MODE_SHORT, MODE_LONG, MODE_TEMP} tdcrs_mode_e;

  typedef struct packed {
    logic valid;
    tdcrs_mode_e mode;
    logic calibrated;
    logic overflow;
    logic [31:0] value;
  } tdcrs_result_s;

  typedef struct packed {
    logic tdc_ovf;
    logic pre_ovf;
    logic sensor_open;
    logic sensor_short;
    logic [2:0] hits1;
    logic [2:0] hits2;
  } tdcrs_meas_s;

endpackage : tdcrs_pkg

// ==== rtl/tdcrs_nvm_mem.sv ====
// Purpose: Seven-word store holding Hamming-protected words.
// Assumes: One access per cycle, synchronous write.
// Notes: Read data come out of a register.
`timescale 1ns/1ps
module tdcrs_nvm_mem #(
  parameter int WORDS = 7,
  parameter int WIDTH = 39
) (
  input wire logic i_clk, // Clock
  input wire logic i_ce, // Clock enable
  input wire logic i_we, // Write strobe
  input wire logic [2:0] i_addr, // Word index
  input wire logic [WIDTH-1:0] i_wdata, // Write data
  output logic [WIDTH-1:0] o_rdata // Registered read data
);
  logic [WIDTH-1:0] mem_ff [WORDS];

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem_ff[i_addr] <= i_wdata;
      end
      o_rdata <= mem_ff[i_addr];
    end
  end
endmodule : tdcrs_nvm_mem

// ==== rtl/tdcrs_regs.sv ====
// Purpose: Result, status and first-wave-ratio registers with protected NVM store.
// Assumes: Command port decoded outside; measurement engines feed results in.
// Notes: NVM contents leave the block only on the recall port, besides compare and status bits.
`timescale 1ns/1ps
module tdcrs_regs #(
  parameter int NVM_OP_CYCLES = tdcrs_pkg::NVM_OP_CYCLES
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_cmd_valid, // Command byte strobe
  input wire logic [7:0] i_cmd, // Command byte
  input wire logic i_shift, // Advance serial read by one bit
  input wire tdcrs_pkg::tdcrs_result_s i_result, // New result from engine
  input wire tdcrs_pkg::tdcrs_meas_s i_meas, // Measurement status levels
  input wire logic [7:0] i_fwr, // First-wave ratio from front end
  input wire logic i_fwr_valid, // First-wave ratio strobe
  input wire logic [1:0] i_div_sel, // ref_clock_divider: 0=1,1=2,2=4
  input wire logic [31:0] i_cfg_word [7], // configuration_registers
  input wire logic [7:0] i_cfg1_hi, // Upper byte of config register 1
  output logic o_sdo, // Serial read data
  output logic [5:0] o_nbits, // Bits remaining in read
  output logic [15:0] o_status, // measurement_status
  output logic [7:0] o_fwr, // first_wave_ratio
  output logic o_nvm_busy, // Store operation running
  output logic o_nvm_done, // Store operation done, one cycle
  output logic o_recall_we, // Recall write strobe to config
  output logic [2:0] o_recall_idx, // Recall config word index
  output logic [31:0] o_recall_data, // Recall config word
  output logic [31:0] o_divider_factor // ref_clock_divider as factor
);

  // ****************************************
  // Hamming SECDED helpers
  // ****************************************
  function automatic logic [38:0] secded_enc(input logic [31:0] d);
    logic [38:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 6; b++) begin
      for (int p = 1; p < 39; p++) begin
        if (((p >> b) & 1) == 1 && p != (1 << b)) begin
          c[(1<<b)-1] = c[(1<<b)-1] ^ c[p-1];
        end
      end
    end
    c[38] = ^c[37:0];
    return c;
  endfunction : secded_enc

  function automatic logic [31:0] secded_data(input logic [38:0] c);
    logic [31:0] d;
    int k;
    d = '0;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p-1];
        k++;
      end
    end
    return d;
  endfunction : secded_data

  // Returns {ded, sec, corrected data}
  function automatic logic [33:0] secded_dec(input logic [38:0] c);
    logic [5:0] syn;
    logic par;
    logic [38:0] fix;
    syn = '0;
    fix = c;
    for (int b = 0; b < 6; b++) begin
      for (int p = 1; p < 39; p++) begin
        if (((p >> b) & 1) == 1) begin
          syn[b] = syn[b] ^ c[p-1];
        end
      end
    end
    par = ^c;
    if (syn != 6'h00 && par && syn < 6'd39) begin
      fix[syn-1] = ~c[syn-1];
    end
    return {(syn != 6'h00) && !par, par, secded_data(fix)};
  endfunction : secded_dec

  // ****************************************
  // Result formatting
  // ****************************************
  logic [31:0] res_ff [4];
  logic [2:0] ptr_ff;
  logic [31:0] fmt;
  logic init_cmd;

  assign init_cmd = i_cmd_valid && i_cmd == tdcrs_pkg::CMD_INIT;

  always_comb begin
    fmt = i_result.value;
    unique case (i_result.mode)
      tdcrs_pkg::MODE_SHORT: begin
        if (i_result.calibrated && i_result.overflow) begin
          fmt = tdcrs_pkg::RES_OVERFLOW;
        end else if (!i_result.calibrated) begin
          fmt = {i_result.value[15:0], tdcrs_pkg::RES_FRAC_ZERO};
        end
      end
      // Long and temperature modes pass the engine value through unchanged
      tdcrs_pkg::MODE_LONG, tdcrs_pkg::MODE_TEMP: begin
        fmt = i_result.value;
      end
      default: fmt = i_result.value;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 4; i++) res_ff[i] <= '0;
    end else if (i_ce && i_result.valid && ptr_ff < 3'd4) begin
      res_ff[ptr_ff[1:0]] <= fmt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_ff <= '0;
    end else if (i_ce) begin
      if (init_cmd) begin
        ptr_ff <= '0;
      end else if (i_result.valid && ptr_ff < 3'd4) begin
        ptr_ff <= ptr_ff + 3'd1;
      end
    end
  end

  // Time per LSB is reference period times this factor
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_divider_factor <= 32'h00000001;
    end else if (i_ce) begin
      o_divider_factor <= 32'h00000001 << i_div_sel[1:0];
    end
  end

  // ****************************************
  // Status and first-wave ratio
  // ****************************************
  logic nvm_sec_ff;
  logic nvm_ded_ff;
  logic nvm_eq_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status <= tdcrs_pkg::STATUS_RESET;
    end else if (i_ce) begin
      o_status[tdcrs_pkg::ST_PTR_LSB +: 3] <= ptr_ff;
      o_status[tdcrs_pkg::ST_HIT1_LSB +: 3] <= i_meas.hits1;
      o_status[tdcrs_pkg::ST_HIT2_LSB +: 3] <= i_meas.hits2;
      o_status[tdcrs_pkg::ST_TDC_OVF] <= i_meas.tdc_ovf;
      o_status[tdcrs_pkg::ST_PRE_OVF] <= i_meas.pre_ovf;
      o_status[tdcrs_pkg::ST_OPEN] <= i_meas.sensor_open;
      o_status[tdcrs_pkg::ST_SHORT] <= i_meas.sensor_short;
      o_status[tdcrs_pkg::ST_NVM_SEC] <= nvm_sec_ff;
      o_status[tdcrs_pkg::ST_NVM_DED] <= nvm_ded_ff;
      o_status[tdcrs_pkg::ST_NVM_EQ] <= nvm_eq_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fwr <= tdcrs_pkg::FWR_RESET;
    end else if (i_ce && i_fwr_valid) begin
      o_fwr <= i_fwr;
    end
  end

  // ****************************************
  // Serial read: MSB first, width by address
  // ****************************************
  logic [31:0] shreg_ff;
  logic rd_cmd;
  logic [3:0] rd_addr;

  assign rd_cmd = i_cmd_valid && i_cmd[7:4] == tdcrs_pkg::CMD_READ_BASE[7:4];
  assign rd_addr = {i_cmd[3], i_cmd[2:0]};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg_ff <= '0;
      o_nbits <= '0;
      o_sdo <= 1'b0;
    end else if (i_ce) begin
      if (rd_cmd) begin
        // Only results, status, ratio and config byte; store words are unreachable
        if (rd_addr <= tdcrs_pkg::ADDR_RES3) begin
          shreg_ff <= res_ff[rd_addr[1:0]];
          o_nbits <= 6'd32;
        end else if (rd_addr == tdcrs_pkg::ADDR_STATUS) begin
          shreg_ff <= {o_status, 16'h0000};
          o_nbits <= 6'd16;
        end else if (rd_addr == tdcrs_pkg::ADDR_CFG1_HI) begin
          shreg_ff <= {i_cfg1_hi, 24'h000000};
          o_nbits <= 6'd8;
        end else if (rd_addr == tdcrs_pkg::ADDR_FWR) begin
          shreg_ff <= {o_fwr, 24'h000000};
          o_nbits <= 6'd8;
        end else begin
          shreg_ff <= '0;
          o_nbits <= '0;
        end
        o_sdo <= 1'b0;
      end else if (i_shift && o_nbits != 6'd0) begin
        o_sdo <= shreg_ff[31];
        shreg_ff <= {shreg_ff[30:0], 1'b0};
        o_nbits <= o_nbits - 6'd1;
      end
    end
  end

  // ****************************************
  // NVM operation sequencer
  // ****************************************
  typedef enum logic [2:0] {NS_IDLE, NS_RUN, NS_READ, NS_CHECK, NS_WAIT} tdcrs_nvm_e;
  tdcrs_nvm_e nvm_st_ff;
  logic [1:0] op_ff; // 0 store, 1 recall, 2 compare
  logic repair_ff;
  logic [2:0] idx_ff;
  logic [31:0] wait_ff;
  logic mem_we;
  logic [38:0] mem_wdata;
  logic [38:0] mem_rdata;
  logic [33:0] dec;
  logic mismatch_ff;

  assign dec = secded_dec(mem_rdata);
  // Rewrite the corrected word in the same CHECK cycle, while idx_ff still points at it
  assign mem_we = (nvm_st_ff == NS_RUN && op_ff == 2'd0) ||
                  (nvm_st_ff == NS_CHECK && dec[32] && !dec[33]);
  assign mem_wdata = (op_ff == 2'd0) ? secded_enc(i_cfg_word[idx_ff]) :
                     secded_enc(dec[31:0]);

  tdcrs_nvm_mem #(
    .WORDS(tdcrs_pkg::NVM_WORDS),
    .WIDTH(tdcrs_pkg::NVM_CODE_W)
  ) u_mem (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_addr(idx_ff),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nvm_st_ff <= NS_IDLE;
      op_ff <= '0;
      repair_ff <= 1'b0;
      idx_ff <= '0;
      wait_ff <= '0;
      mismatch_ff <= 1'b0;
    end else if (i_ce) begin
      unique case (nvm_st_ff)
        NS_IDLE: begin
          idx_ff <= '0;
          repair_ff <= 1'b0;
          mismatch_ff <= 1'b0;
          if (i_cmd_valid) begin
            // Any other command code leaves the store untouched
            if (i_cmd == tdcrs_pkg::CMD_NVM_STORE) begin
              op_ff <= 2'd0;
              nvm_st_ff <= NS_RUN;
            end else if (i_cmd == tdcrs_pkg::CMD_NVM_RECALL) begin
              op_ff <= 2'd1;
              nvm_st_ff <= NS_READ;
            end else if (i_cmd == tdcrs_pkg::CMD_NVM_COMPARE) begin
              op_ff <= 2'd2;
              nvm_st_ff <= NS_READ;
            end
          end
        end
        NS_RUN: begin
          if (idx_ff == 3'(tdcrs_pkg::NVM_WORDS - 1)) begin
            nvm_st_ff <= NS_WAIT;
            wait_ff <= '0;
          end else begin
            idx_ff <= idx_ff + 3'd1;
          end
        end
        NS_READ: begin
          nvm_st_ff <= NS_CHECK;
        end
        NS_CHECK: begin
          if (dec[32] && !dec[33]) begin
            repair_ff <= 1'b1;
          end
          if (dec[31:0] != i_cfg_word[idx_ff]) begin
            mismatch_ff <= 1'b1;
          end
          if (idx_ff == 3'(tdcrs_pkg::NVM_WORDS - 1)) begin
            nvm_st_ff <= NS_WAIT;
            wait_ff <= '0;
          end else begin
            idx_ff <= idx_ff + 3'd1;
            nvm_st_ff <= NS_READ;
          end
        end
        NS_WAIT: begin
          if (wait_ff == 32'(NVM_OP_CYCLES - 1)) begin
            nvm_st_ff <= NS_IDLE;
          end else begin
            wait_ff <= wait_ff + 32'd1;
          end
        end
        default: nvm_st_ff <= NS_IDLE;
      endcase
    end
  end

  // Repair rewrites the word in the CHECK cycle using corrected data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nvm_sec_ff <= 1'b0;
      nvm_ded_ff <= 1'b0;
    end else if (i_ce) begin
      if (nvm_st_ff == NS_IDLE && i_cmd_valid &&
          (i_cmd == tdcrs_pkg::CMD_NVM_RECALL || i_cmd == tdcrs_pkg::CMD_NVM_COMPARE)) begin
        nvm_sec_ff <= 1'b0;
        nvm_ded_ff <= 1'b0;
      end else if (nvm_st_ff == NS_CHECK) begin
        if (dec[32] && !dec[33]) nvm_sec_ff <= 1'b1;
        if (dec[33]) nvm_ded_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nvm_eq_ff <= 1'b0;
    end else if (i_ce && op_ff == 2'd2 && nvm_st_ff == NS_WAIT && wait_ff == '0) begin
      nvm_eq_ff <= !mismatch_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_recall_we <= 1'b0;
      o_recall_idx <= '0;
      o_recall_data <= '0;
      o_nvm_busy <= 1'b0;
      o_nvm_done <= 1'b0;
    end else if (i_ce) begin
      o_recall_we <= nvm_st_ff == NS_CHECK && op_ff == 2'd1 && !dec[33];
      o_recall_idx <= idx_ff;
      o_recall_data <= dec[31:0];
      o_nvm_busy <= nvm_st_ff != NS_IDLE;
      o_nvm_done <= nvm_st_ff == NS_WAIT && wait_ff == 32'(NVM_OP_CYCLES - 1);
    end
  end

endmodule : tdcrs_regs

// ==== dv/tdcrs_regs_chk.sv ====
// Purpose: Port-level checks of the result, status and store block.
// Assumes: One clock, async active-low reset, status lags inputs one cycle.
// Notes: Error injection in the store is out of reach from the ports.
`timescale 1ns/1ps
module tdcrs_regs_chk (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_cmd_valid, // Command strobe
  input wire logic [7:0] i_cmd, // Command byte
  input wire tdcrs_pkg::tdcrs_meas_s i_meas, // Measurement levels
  input wire logic [1:0] i_div_sel, // Divider select
  input wire logic [5:0] o_nbits, // Bits left
  input wire logic [15:0] o_status, // Status word
  input wire logic o_nvm_busy, // Store busy
  input wire logic o_nvm_done, // Store done
  input wire logic [31:0] o_divider_factor // Divider factor
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // Status word
  // ****************************************
  ptr_clear_a: assert property (
    i_ce && i_cmd_valid && i_cmd == 8'h70 |-> ##[1:2] o_status[2:0] == 3'h0)
    else $error("Pointer not cleared by init");
  ptr_range_a: assert property (o_status[2:0] <= 3'h4)
    else $error("Pointer beyond last result");
  hit_counts_a: assert property (
    i_ce && $past(i_ce) |-> o_status[8:3] == {$past(i_meas.hits2), $past(i_meas.hits1)})
    else $error("Hit counts wrong");
  tdc_ovf_a: assert property (
    i_ce && $past(i_ce) |-> o_status[9] == $past(i_meas.tdc_ovf))
    else $error("Time unit overflow flag wrong");
  pre_ovf_a: assert property (
    i_ce && $past(i_ce) |-> o_status[10] == $past(i_meas.pre_ovf))
    else $error("Precounter overflow flag wrong");
  sensor_flags_a: assert property (
    i_ce && $past(i_ce) |->
    o_status[12:11] == {$past(i_meas.sensor_short), $past(i_meas.sensor_open)})
    else $error("Sensor flags wrong");
  // ****************************************
  // Commands, reads and divider
  // ****************************************
  read_len_a: assert property (
    i_ce && i_cmd_valid && i_cmd[7:4] == 4'hb && i_cmd[3:0] < 4'h4 |=> o_nbits == 6'd32)
    else $error("Result read length wrong");
  no_store_read_a: assert property (
    i_ce && i_cmd_valid && i_cmd inside {8'hb6, 8'hb7} |=> o_nbits == 6'd0)
    else $error("Store contents offered for reading");
  nvm_start_a: assert property (
    i_ce && i_cmd_valid && !o_nvm_busy && i_cmd inside {8'hc0, 8'hf0, 8'hc6} |=>
    ##1 o_nvm_busy)
    else $error("Store operation did not start");
  nvm_end_a: assert property (o_nvm_done |-> o_nvm_busy ##1 !o_nvm_busy)
    else $error("Store completion out of order");
  div_factor_a: assert property (
    i_ce && i_div_sel != 2'h3 && i_div_sel == $past(i_div_sel) |=>
    o_divider_factor == (32'h1 << $past(i_div_sel)))
    else $error("Divider factor wrong");
endmodule : tdcrs_regs_chk

bind tdcrs_regs tdcrs_regs_chk tdcrs_regs_chk_inst (.i_clk, .i_rst_n, .i_ce, .i_cmd_valid,
  .i_cmd, .i_meas, .i_div_sel, .o_nbits, .o_status, .o_nvm_busy, .o_nvm_done,
  .o_divider_factor);

// ==== dv/tdcrs_host.sv ====
// Purpose: Host model on the command port: commands, serial reads, store ops.
// Assumes: Signals change only at rising edges.
// Notes: Command byte shows its inverse once the strobe is released.
`timescale 1ns/1ps
module tdcrs_host (
  input wire logic i_clk, // Clock
  input wire logic i_sdo, // Serial read bit
  input wire logic [5:0] i_nbits, // Bits left in read
  input wire logic i_done, // Store op done pulse
  output logic o_cmd_valid, // Command strobe
  output logic [7:0] o_cmd, // Command byte
  output logic o_shift // Shift strobe
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = 8'h00;
    o_shift = 1'b0;
  end
  task automatic send(input logic [7:0] c);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_cmd <= ~c;
  endtask : send
  task automatic read(input logic [3:0] a, input int n, output logic [5:0] len,
                      output logic [31:0] v);
    int i;
    v = 32'h0;
    send({4'hb, a});
    @(posedge i_clk);
    @(posedge i_clk);
    len = i_nbits;
    if (n > 0) o_shift <= 1'b1;
    for (i = 0; i <= n; i++) begin
      @(posedge i_clk);
      if (i == n - 1) o_shift <= 1'b0;
      if (i > 0) v = {v[30:0], i_sdo};
    end
  endtask : read
  // Returns once the device reports completion, or after 300 cycles without it
  task automatic nvm(input logic [7:0] c, output logic ok);
    int i;
    ok = 1'b0;
    send(c);
    for (i = 0; i < 300 && !ok; i++) begin
      @(posedge i_clk);
      ok = (i_done === 1'b1);
    end
  endtask : nvm
endmodule : tdcrs_host

// ==== dv/tdc_result_status_nvm_store_bench.sv ====
// Purpose: Self-checking bench of the result, status and store block.
// Assumes: Store wait shortened to 20 cycles.
// Notes: Expected words are worked out by hand from the number formats.
`timescale 1ns/1ps
module tdc_result_status_nvm_store_bench;
  logic i_clk = 1'b0;
  logic i_rst_n, i_ce, i_cmd_valid, i_shift, i_fwr_valid, ok;
  logic o_sdo, o_nvm_busy, o_nvm_done, o_recall_we;
  logic [7:0] i_cmd, i_fwr, i_cfg1_hi, o_fwr;
  logic [1:0] i_div_sel;
  logic [31:0] i_cfg_word [7];
  logic [31:0] saved [7];
  logic [31:0] te [5];
  logic [31:0] v, o_recall_data, o_divider_factor;
  logic [5:0] o_nbits, len;
  logic [15:0] o_status;
  logic [2:0] o_recall_idx;
  tdcrs_pkg::tdcrs_result_s i_result;
  tdcrs_pkg::tdcrs_result_s tr [5];
  tdcrs_pkg::tdcrs_meas_s i_meas;
  int bad_count = 0;
  int num_checks = 0;
  int recalls = 0;
  int k;
  always #5 i_clk = ~i_clk;
  tdcrs_regs #(.NVM_OP_CYCLES(20)) tdcrs_regs_inst (.i_clk, .i_rst_n, .i_ce, .i_cmd_valid,
    .i_cmd, .i_shift, .i_result, .i_meas, .i_fwr, .i_fwr_valid, .i_div_sel, .i_cfg_word,
    .i_cfg1_hi, .o_sdo, .o_nbits, .o_status, .o_fwr, .o_nvm_busy, .o_nvm_done,
    .o_recall_we, .o_recall_idx, .o_recall_data, .o_divider_factor);
  tdcrs_host tdcrs_host_inst (.i_clk, .i_sdo(o_sdo), .i_nbits(o_nbits), .i_done(o_nvm_done),
    .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_shift(i_shift));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input int n, input logic [31:0] e);
    tdcrs_host_inst.read(a, n, len, v);
    chk({26'h0, len}, n);
    chk(v, e);
  endtask : rd
  task automatic put(input tdcrs_pkg::tdcrs_result_s r);
    @(posedge i_clk);
    i_result <= r;
    @(posedge i_clk);
    i_result.valid <= 1'b0;
  endtask : put
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // Every recalled word must be the one stored before
  always @(posedge i_clk) begin
    if (o_recall_we === 1'b1) begin
      recalls++;
      chk(o_recall_data, saved[o_recall_idx]);
    end
  end
  initial begin
    #50us;
    bad_count++;
    print_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    tr[0] = '{1'b1, tdcrs_pkg::MODE_SHORT, 1'b0, 1'b0, 32'h1234_abcd};
    tr[1] = '{1'b1, tdcrs_pkg::MODE_SHORT, 1'b1, 1'b1, 32'h0000_1111};
    tr[2] = '{1'b1, tdcrs_pkg::MODE_LONG, 1'b1, 1'b0, 32'h8003_8000};
    tr[3] = '{1'b1, tdcrs_pkg::MODE_TEMP, 1'b1, 1'b0, 32'h0001_4000};
    tr[4] = '{1'b1, tdcrs_pkg::MODE_SHORT, 1'b1, 1'b0, 32'hfffe_8000};
    te = '{32'habcd_0000, 32'h0fff_ffff, 32'h8003_8000, 32'h0001_4000, 32'hfffe_8000};
    for (k = 0; k < 7; k++) begin
      i_cfg_word[k] = 32'h5a5a_0000 + k;
      saved[k] = 32'h5a5a_0000 + k;
    end
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_result = '0;
    i_meas = '0;
    i_fwr = 8'h00;
    i_fwr_valid = 1'b0;
    i_div_sel = 2'h0;
    i_cfg1_hi = 8'h3c;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chk({16'h0, o_status}, 32'h0);
    chk({24'h0, o_fwr}, 32'h0);
    chk(o_divider_factor, 32'h1);
    $display("test reset done");
    for (k = 0; k < 3; k++) begin
      @(posedge i_clk);
      i_div_sel <= k[1:0];
      repeat (3) @(posedge i_clk);
      chk(o_divider_factor, 32'h1 << k);
    end
    $display("test divider done");
    for (k = 0; k < 4; k++) put(tr[k]);
    put(tr[4]);
    for (k = 0; k < 4; k++) rd(k[3:0], 32, te[k]);
    rd(4'h4, 16, 32'h0004);
    tdcrs_host_inst.send(8'h70);
    rd(4'h4, 16, 32'h0000);
    put(tr[4]);
    rd(4'h0, 32, te[4]);
    $display("test results done");
    i_meas <= '{1'b1, 1'b0, 1'b1, 1'b0, 3'h5, 3'h2};
    rd(4'h4, 16, 32'h0aa9);
    i_meas <= '{1'b0, 1'b1, 1'b0, 1'b1, 3'h2, 3'h5};
    rd(4'h4, 16, 32'h1551);
    i_meas <= '0;
    @(posedge i_clk);
    i_fwr <= 8'hff;
    i_fwr_valid <= 1'b1;
    @(posedge i_clk);
    i_fwr_valid <= 1'b0;
    rd(4'h8, 8, 32'hff);
    rd(4'h5, 8, 32'h3c);
    rd(4'h6, 0, 32'h0);
    rd(4'h7, 0, 32'h0);
    @(posedge i_clk);
    i_ce <= 1'b0;
    put(tr[4]);
    i_ce <= 1'b1;
    rd(4'h4, 16, 32'h0001);
    $display("test status done");
    tdcrs_host_inst.nvm(8'hc0, ok);
    chk({31'h0, ok}, 32'h1);
    tdcrs_host_inst.nvm(8'hc6, ok);
    rd(4'h4, 16, 32'h8001);
    @(posedge i_clk);
    i_cfg_word[3] <= 32'h0;
    tdcrs_host_inst.nvm(8'hc6, ok);
    rd(4'h4, 16, 32'h0001);
    tdcrs_host_inst.nvm(8'hf0, ok);
    chk(32'(recalls), 32'd7);
    $display("test store done");
    print_verdict();
  end
endmodule : tdc_result_status_nvm_store_bench
